// >>> src/port_pin_consts.vh
// Purpose: shared constants for the port pin override mux
// Assumes: one 8-bit port, register port with 2-bit address
// Notes:   definitions only
`ifndef PORT_PIN_CONSTS_VH
`define PORT_PIN_CONSTS_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define PORT_WIDTH        8
`define ADDR_WIDTH        2

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ADDR_INPUT        2'h0
`define ADDR_DIRECTION    2'h1
`define ADDR_LATCH        2'h2
`define ADDR_CONTROL      2'h3

// ----------------------------------------------------------------
// control register field positions
// ----------------------------------------------------------------
`define CTL_PULLUP_DIS    0
`define CTL_ASYNC_TIMER   1
`define CTL_EXT_CLOCK     2
`define CTL_MAIN_OSC      3
`define CTL_USED_BITS     4

// ----------------------------------------------------------------
// reset values and special bits
// ----------------------------------------------------------------
`define RST_BYTE          8'h00
`define RST_CTL           4'h0
`define OSC_PIN_BIT       7
`define ZERO_BIT          1'b0

`endif

// >>> src/input_sync3.v
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input comes from outside the clock domain
// Notes:   output changes only once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
`include "port_pin_consts.vh"

module input_sync3 (
  input  wire clk,
  input  wire reset_n,
  input  wire async_in,
  output reg  sync_out
);

  reg stage1_reg;
  reg stage2_reg;
  reg stage3_reg;

  // ----------------------------------------------------------------
  // sync chain
  // ----------------------------------------------------------------
  // first stage feeds only the second
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_reg <= `ZERO_BIT;
      stage2_reg <= `ZERO_BIT;
      stage3_reg <= `ZERO_BIT;
      sync_out   <= `ZERO_BIT;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      if (stage2_reg == stage3_reg) begin
        sync_out <= stage3_reg;
      end
    end
  end

endmodule // input_sync3
`default_nettype wire

// >>> src/pin_override_cell.v
// Purpose: resolves one pin's pad controls from registers and overrides
// Assumes: all inputs are on the port clock
// Notes:   pure combinational, one instance per pin
`timescale 1ns/1ns
`default_nettype none

module pin_override_cell (
  input  wire pin_direction_bit,
  input  wire pin_output_latch_bit,
  input  wire global_pullup_disable,
  input  wire sleep_clamp,
  input  wire pullup_override_en,
  input  wire pullup_override_val,
  input  wire drive_dir_override_en,
  input  wire drive_dir_override_val,
  input  wire out_value_override_en,
  input  wire out_value_override_val,
  input  wire input_en_override_en,
  input  wire input_en_override_val,
  output wire drive_en,
  output wire drive_value,
  output wire pullup_en,
  output wire input_en
);

  // ----------------------------------------------------------------
  // pull-up
  // ----------------------------------------------------------------
  // override value alone, else pattern dir=0, latch=1, disable=0
  assign pullup_en = pullup_override_en ? pullup_override_val
                   : (~pin_direction_bit & pin_output_latch_bit
                      & ~global_pullup_disable);

  // ----------------------------------------------------------------
  // output driver and value
  // ----------------------------------------------------------------
  assign drive_en = drive_dir_override_en ? drive_dir_override_val
                  : pin_direction_bit;
  assign drive_value = out_value_override_en ? out_value_override_val
                     : pin_output_latch_bit;

  // ----------------------------------------------------------------
  // digital input enable
  // ----------------------------------------------------------------
  assign input_en = input_en_override_en ? input_en_override_val
                  : ~sleep_clamp;

endmodule // pin_override_cell
`default_nettype wire

// >>> src/port_pin_override_mux.v
// Purpose: port registers plus per-pin alternate function override mux
// Assumes: one 20 MHz clock, register port with one-cycle read data
// Notes:   bit 7 doubles as oscillator pin; overrides are per pin
//
// What this block does
// - pull-up override enable selects override value
// - otherwise pull-up when dir,latch,disable = 010
// - override pull-up ignores dir, latch, disable
// - direction override enable selects override value
// - otherwise driver follows direction bit
// - override driver ignores direction bit
// - driving with value override drives override value
// - driving without override drives latch bit
// - toggle override inverts the latch bit
// - input override enable selects override value
// - otherwise input enable follows sleep state
// - override input enable ignores sleep state
// - alternate input taken before the synchroniser
// - analog link connects straight to the pad
// - register strobes shared by all port pins
// - clock, sleep clamp, pull-up disable shared
// - oscillator bit 7 is no general I/O
// - async timer crystal mode detaches bit 7
// - bit 7 feeds the pin-change logic
// - clock pin bit 7 reads back zero
// - sleep controller clamps inputs in deep sleep
// - writing input register toggles latch bits
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "port_pin_consts.vh"

module port_pin_override_mux (
  input  wire                      CLK,
  input  wire                      RESET_N,
  // register port
  input  wire [`ADDR_WIDTH-1:0]    ADDR,
  input  wire [`PORT_WIDTH-1:0]    WDATA,
  input  wire                      WR,
  input  wire                      RD,
  output reg  [`PORT_WIDTH-1:0]    RDATA,
  // shared sleep clamp from the sleep controller
  input  wire                      SLEEP_CLAMP,
  // per-pin overrides from the peripheral modules
  input  wire [`PORT_WIDTH-1:0]    PULLUP_OVERRIDE_EN,
  input  wire [`PORT_WIDTH-1:0]    PULLUP_OVERRIDE_VAL,
  input  wire [`PORT_WIDTH-1:0]    DRIVE_DIR_OVERRIDE_EN,
  input  wire [`PORT_WIDTH-1:0]    DRIVE_DIR_OVERRIDE_VAL,
  input  wire [`PORT_WIDTH-1:0]    OUT_VALUE_OVERRIDE_EN,
  input  wire [`PORT_WIDTH-1:0]    OUT_VALUE_OVERRIDE_VAL,
  input  wire [`PORT_WIDTH-1:0]    LATCH_TOGGLE_OVERRIDE_EN,
  input  wire [`PORT_WIDTH-1:0]    INPUT_EN_OVERRIDE_EN,
  input  wire [`PORT_WIDTH-1:0]    INPUT_EN_OVERRIDE_VAL,
  // pad side
  input  wire [`PORT_WIDTH-1:0]    PAD_IN,
  output reg  [`PORT_WIDTH-1:0]    PAD_OUT,
  output reg  [`PORT_WIDTH-1:0]    PAD_OE_N,
  output reg  [`PORT_WIDTH-1:0]    PULLUP_EN,
  output reg  [`PORT_WIDTH-1:0]    INPUT_EN,
  // toward the alternate functions
  output wire [`PORT_WIDTH-1:0]    RAW_ALT_INPUT,
  output wire [`PORT_WIDTH-1:0]    ANALOG_PAD_LINK,
  output reg                       PIN_CHANGE_SOURCE_7,
  output reg                       BIT7_IS_CLOCK_PIN
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg  [`PORT_WIDTH-1:0]   direction_reg;
  reg  [`PORT_WIDTH-1:0]   direction_next;
  reg  [`PORT_WIDTH-1:0]   latch_reg;
  reg  [`PORT_WIDTH-1:0]   latch_next;
  reg  [`CTL_USED_BITS-1:0] control_reg;
  reg  [`CTL_USED_BITS-1:0] control_next;
  reg  [`PORT_WIDTH-1:0]   rdata_next;
  reg  [`PORT_WIDTH-1:0]   toggle_mask;
  wire [`PORT_WIDTH-1:0]   input_sync;
  wire [`PORT_WIDTH-1:0]   gated_in;
  wire [`PORT_WIDTH-1:0]   cell_drive_en;
  wire [`PORT_WIDTH-1:0]   cell_drive_value;
  wire [`PORT_WIDTH-1:0]   cell_pullup_en;
  wire [`PORT_WIDTH-1:0]   cell_input_en;
  wire [`PORT_WIDTH-1:0]   clock_pin_mask;
  wire [`PORT_WIDTH-1:0]   final_drive_en;
  wire [`PORT_WIDTH-1:0]   final_pullup_en;
  wire [`PORT_WIDTH-1:0]   final_input_en;
  wire [`PORT_WIDTH-1:0]   read_dir;
  wire [`PORT_WIDTH-1:0]   read_latch;
  wire [`PORT_WIDTH-1:0]   read_input;
  wire                     global_pullup_disable;
  wire                     async_timer_clock_sel;
  wire                     external_clock_input_sel;
  wire                     main_osc_pin_sel;
  wire                     clock_pin_mode;
  wire                     wr_input;
  wire                     wr_direction;
  wire                     wr_latch;
  wire                     wr_control;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  // one pull-up disable and one clock mode for the whole port
  assign global_pullup_disable    = control_reg[`CTL_PULLUP_DIS];
  assign async_timer_clock_sel    = control_reg[`CTL_ASYNC_TIMER];
  assign external_clock_input_sel = control_reg[`CTL_EXT_CLOCK];
  assign main_osc_pin_sel         = control_reg[`CTL_MAIN_OSC];

  // bit 7 is an oscillator pin in crystal mode, or in async timer mode without external clock input
  assign clock_pin_mode = main_osc_pin_sel
                        | (async_timer_clock_sel
                           & ~external_clock_input_sel);

  // mask holding only bit 7 while it serves as clock pin
  genvar gi;
  generate
    for (gi = 0; gi < `PORT_WIDTH; gi = gi + 1) begin : g_mask
      if (gi == `OSC_PIN_BIT) begin : g_osc
        assign clock_pin_mask[gi] = clock_pin_mode;
      end else begin : g_gpio
        assign clock_pin_mask[gi] = `ZERO_BIT;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // write strobe decode
  // ----------------------------------------------------------------
  // strobes are per port, every pin sees the same ones
  assign wr_input     = WR & (ADDR == `ADDR_INPUT);
  assign wr_direction = WR & (ADDR == `ADDR_DIRECTION);
  assign wr_latch     = WR & (ADDR == `ADDR_LATCH);
  assign wr_control   = WR & (ADDR == `ADDR_CONTROL);

  // ----------------------------------------------------------------
  // per-pin override cells
  // ----------------------------------------------------------------
  // each peripheral supplies its own enable and value pairs
  generate
    for (gi = 0; gi < `PORT_WIDTH; gi = gi + 1) begin : g_pin
      pin_override_cell u_cell (
        .pin_direction_bit      (direction_reg[gi]),
        .pin_output_latch_bit   (latch_reg[gi]),
        .global_pullup_disable  (global_pullup_disable),
        .sleep_clamp            (SLEEP_CLAMP),
        .pullup_override_en     (PULLUP_OVERRIDE_EN[gi]),
        .pullup_override_val    (PULLUP_OVERRIDE_VAL[gi]),
        .drive_dir_override_en  (DRIVE_DIR_OVERRIDE_EN[gi]),
        .drive_dir_override_val (DRIVE_DIR_OVERRIDE_VAL[gi]),
        .out_value_override_en  (OUT_VALUE_OVERRIDE_EN[gi]),
        .out_value_override_val (OUT_VALUE_OVERRIDE_VAL[gi]),
        .input_en_override_en   (INPUT_EN_OVERRIDE_EN[gi]),
        .input_en_override_val  (INPUT_EN_OVERRIDE_VAL[gi]),
        .drive_en               (cell_drive_en[gi]),
        .drive_value            (cell_drive_value[gi]),
        .pullup_en              (cell_pullup_en[gi]),
        .input_en               (cell_input_en[gi])
      );

      // port synchroniser sits after the input gate
      input_sync3 u_sync (
        .clk      (CLK),
        .reset_n  (RESET_N),
        .async_in (gated_in[gi]),
        .sync_out (input_sync[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // clock pin takeover
  // ----------------------------------------------------------------
  // a detached bit 7 neither drives, pulls nor reads digitally
  assign final_drive_en  = cell_drive_en  & ~clock_pin_mask;
  assign final_pullup_en = cell_pullup_en & ~clock_pin_mask;
  assign final_input_en  = cell_input_en  & ~clock_pin_mask;

  // ----------------------------------------------------------------
  // input paths
  // ----------------------------------------------------------------
  // disabled input presents zero to sync and alternate path
  assign gated_in = PAD_IN & final_input_en;

  // alternate input taken ahead of the port synchroniser
  assign RAW_ALT_INPUT = gated_in;

  // analog link sees the pad with no digital gating
  assign ANALOG_PAD_LINK = PAD_IN;

  // ----------------------------------------------------------------
  // read-back masking
  // ----------------------------------------------------------------
  assign read_dir   = direction_reg & ~clock_pin_mask;
  assign read_latch = latch_reg     & ~clock_pin_mask;
  assign read_input = input_sync    & ~clock_pin_mask;

  // ----------------------------------------------------------------
  // register next values
  // ----------------------------------------------------------------
  // latch toggles come from input writes and from peripherals
  always @* begin
    direction_next = direction_reg;
    control_next   = control_reg;
    toggle_mask    = LATCH_TOGGLE_OVERRIDE_EN;
    if (wr_direction) begin
      direction_next = WDATA;
    end
    if (wr_control) begin
      control_next = WDATA[`CTL_USED_BITS-1:0];
    end
    if (wr_input) begin
      toggle_mask = toggle_mask ^ WDATA;
    end
    if (wr_latch) begin
      latch_next = WDATA ^ toggle_mask;
    end else begin
      latch_next = latch_reg ^ toggle_mask;
    end
  end

  // read mux, data stands in the cycle after the strobe
  always @* begin
    rdata_next = `RST_BYTE;
    if (RD) begin
      case (ADDR)
        `ADDR_INPUT:     rdata_next = read_input;
        `ADDR_DIRECTION: rdata_next = read_dir;
        `ADDR_LATCH:     rdata_next = read_latch;
        `ADDR_CONTROL:   rdata_next = {{(`PORT_WIDTH-`CTL_USED_BITS){1'b0}},
                                       control_reg};
        default:         rdata_next = `RST_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      direction_reg <= `RST_BYTE;
      latch_reg     <= `RST_BYTE;
      control_reg   <= `RST_CTL;
      RDATA         <= `RST_BYTE;
    end else begin
      direction_reg <= direction_next;
      latch_reg     <= latch_next;
      control_reg   <= control_next;
      RDATA         <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // pad outputs
  // ----------------------------------------------------------------
  // enables are active low while driving; reset leaves pads released
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PAD_OUT             <= `RST_BYTE;
      PAD_OE_N            <= ~`RST_BYTE;
      PULLUP_EN           <= `RST_BYTE;
      INPUT_EN            <= `RST_BYTE;
      PIN_CHANGE_SOURCE_7 <= `ZERO_BIT;
      BIT7_IS_CLOCK_PIN   <= `ZERO_BIT;
    end else begin
      PAD_OUT             <= cell_drive_value & final_drive_en;
      PAD_OE_N            <= ~final_drive_en;
      PULLUP_EN           <= final_pullup_en;
      INPUT_EN            <= final_input_en;
      PIN_CHANGE_SOURCE_7 <= input_sync[`OSC_PIN_BIT];
      BIT7_IS_CLOCK_PIN   <= clock_pin_mode;
    end
  end

endmodule // port_pin_override_mux
`default_nettype wire

// >>> verification/port_pin_override_mux_asserts.sv
// Purpose: port-level checks for the pin override mux
// Assumes: single clock, asynchronous active-low reset
// Notes:   bit 7 masked where oscillator mode may own it
`timescale 1ns/1ns
`default_nettype none
module port_pin_override_mux_asserts (
  input wire logic       CLK,
  input wire logic       RESET_N,
  input wire logic       SLEEP_CLAMP,
  input wire logic [7:0] PULLUP_OVERRIDE_EN,
  input wire logic [7:0] PULLUP_OVERRIDE_VAL,
  input wire logic [7:0] DRIVE_DIR_OVERRIDE_EN,
  input wire logic [7:0] DRIVE_DIR_OVERRIDE_VAL,
  input wire logic [7:0] OUT_VALUE_OVERRIDE_EN,
  input wire logic [7:0] OUT_VALUE_OVERRIDE_VAL,
  input wire logic [7:0] LATCH_TOGGLE_OVERRIDE_EN,
  input wire logic [7:0] INPUT_EN_OVERRIDE_EN,
  input wire logic [7:0] INPUT_EN_OVERRIDE_VAL,
  input wire logic [7:0] PAD_IN,
  input wire logic [7:0] PAD_OUT,
  input wire logic [7:0] PAD_OE_N,
  input wire logic [7:0] PULLUP_EN,
  input wire logic [7:0] INPUT_EN,
  input wire logic [7:0] RAW_ALT_INPUT,
  input wire logic [7:0] ANALOG_PAD_LINK,
  input wire logic       BIT7_IS_CLOCK_PIN
);
  localparam logic [7:0] LOW7 = 8'h7f; // pins never taken by the oscillator
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  // ------------------------------------------------------------
  // registered pad controls follow their overrides one cycle on
  // ------------------------------------------------------------
  AST_PULLUP_OVR: assert property ($past(RESET_N) |->
    ((PULLUP_EN ^ $past(PULLUP_OVERRIDE_VAL)) & $past(PULLUP_OVERRIDE_EN) & LOW7) == 8'h00)
    else $error("pull-up ignores its override");
  AST_DRIVE_OVR: assert property ($past(RESET_N) |->
    ((PAD_OE_N ^ ~$past(DRIVE_DIR_OVERRIDE_VAL)) & $past(DRIVE_DIR_OVERRIDE_EN) & LOW7) == 8'h00)
    else $error("driver enable ignores its override");
  AST_VALUE_OVR: assert property ($past(RESET_N) |-> ((PAD_OUT ^ $past(OUT_VALUE_OVERRIDE_VAL))
    & $past(OUT_VALUE_OVERRIDE_EN & DRIVE_DIR_OVERRIDE_EN & DRIVE_DIR_OVERRIDE_VAL) & LOW7) == 8'h00)
    else $error("pad value ignores its override");
  AST_INEN_OVR: assert property ($past(RESET_N) |->
    ((INPUT_EN ^ $past(INPUT_EN_OVERRIDE_VAL)) & $past(INPUT_EN_OVERRIDE_EN) & LOW7) == 8'h00)
    else $error("input enable ignores its override");
  AST_SLEEP_OFF: assert property ($past(RESET_N) && $past(SLEEP_CLAMP) |->
    (INPUT_EN & ~$past(INPUT_EN_OVERRIDE_EN) & LOW7) == 8'h00)
    else $error("input stays enabled under sleep clamp");
  AST_RAW_GATED: assert property (
    (RAW_ALT_INPUT & INPUT_EN_OVERRIDE_EN & ~INPUT_EN_OVERRIDE_VAL & LOW7) == 8'h00)
    else $error("disabled input leaks to alternate path");
  AST_RAW_DIRECT: assert property (
    ((RAW_ALT_INPUT ^ PAD_IN) & INPUT_EN_OVERRIDE_EN & INPUT_EN_OVERRIDE_VAL & LOW7) == 8'h00)
    else $error("alternate input not taken straight from pad");
  AST_ANALOG_LINK: assert property (ANALOG_PAD_LINK == PAD_IN)
    else $error("analog link differs from pad");
  AST_CLOCK_PIN: assert property (BIT7_IS_CLOCK_PIN && $past(BIT7_IS_CLOCK_PIN) |->
    PAD_OE_N[7] && !PULLUP_EN[7] && !INPUT_EN[7])
    else $error("oscillator pin still acts as port pin");
  cover property (SLEEP_CLAMP && (|INPUT_EN_OVERRIDE_EN));
  cover property (BIT7_IS_CLOCK_PIN);
  cover property (|LATCH_TOGGLE_OVERRIDE_EN);
endmodule // port_pin_override_mux_asserts
bind port_pin_override_mux port_pin_override_mux_asserts u_checker (
  .CLK, .RESET_N, .SLEEP_CLAMP, .PULLUP_OVERRIDE_EN, .PULLUP_OVERRIDE_VAL,
  .DRIVE_DIR_OVERRIDE_EN, .DRIVE_DIR_OVERRIDE_VAL, .OUT_VALUE_OVERRIDE_EN,
  .OUT_VALUE_OVERRIDE_VAL, .LATCH_TOGGLE_OVERRIDE_EN, .INPUT_EN_OVERRIDE_EN,
  .INPUT_EN_OVERRIDE_VAL, .PAD_IN, .PAD_OUT, .PAD_OE_N, .PULLUP_EN, .INPUT_EN,
  .RAW_ALT_INPUT, .ANALOG_PAD_LINK, .BIT7_IS_CLOCK_PIN);
`default_nettype wire

// >>> verification/pad_far_side.sv
// Purpose: model of the pad and of a peripheral taking the raw input
// Assumes: outside driver controlled by the bench per pin
// Notes:   an undriven pin without pull-up drifts to the inverse level
`timescale 1ns/1ns
`default_nettype none
module pad_far_side (
  input  wire logic       clk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe_n,
  input  wire logic [7:0] pullup_en,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_level,
  input  wire logic [7:0] raw_alt_input,
  output logic      [7:0] pad_level,
  output logic      [7:0] alt_sync
);
  // known start level, so a floating pin never carries an unknown into the mux
  logic [7:0] last_reg = 8'h00;
  logic [7:0] meta_reg;
  // chip driver first, then outside driver, then pull-up, else drift
  assign pad_level = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_level)
                   | (pad_oe_n & ~ext_en & (pullup_en | ~last_reg));
  // remembers the level and resamples the raw input in the peripheral
  always @(posedge clk) begin
    last_reg <= pad_level;
    meta_reg <= raw_alt_input;
    alt_sync <= meta_reg;
  end
endmodule // pad_far_side
`default_nettype wire

// >>> verification/tb.sv
// Purpose: self-checking bench for the pin override mux
// Assumes: 20 MHz clock, register port with one-cycle read data
// Notes:   overrides come straight from the bench in the peripherals' place
`timescale 1ns/1ns
`default_nettype none
`include "port_pin_consts.vh"
module tb;
  logic       CLK, RESET_N, WR, RD, SLEEP_CLAMP, PIN_CHANGE_SOURCE_7, BIT7_IS_CLOCK_PIN;
  logic [1:0] ADDR;
  logic [7:0] WDATA, RDATA, PULLUP_OVERRIDE_EN, PULLUP_OVERRIDE_VAL, DRIVE_DIR_OVERRIDE_EN;
  logic [7:0] DRIVE_DIR_OVERRIDE_VAL, OUT_VALUE_OVERRIDE_EN, OUT_VALUE_OVERRIDE_VAL;
  logic [7:0] LATCH_TOGGLE_OVERRIDE_EN, INPUT_EN_OVERRIDE_EN, INPUT_EN_OVERRIDE_VAL, PAD_IN;
  logic [7:0] PAD_OUT, PAD_OE_N, PULLUP_EN, INPUT_EN, RAW_ALT_INPUT, ANALOG_PAD_LINK;
  logic [7:0] ext_en, ext_level, alt_sync, rd_val;
  logic [7:0] ctl_tab [4] = '{8'h02, 8'h06, 8'h08, 8'h00};
  logic [3:0] clk_tab = 4'b0101;
  int         miscompares, samples_checked, cycles;
  port_pin_override_mux DUT (.CLK, .RESET_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .SLEEP_CLAMP,
    .PULLUP_OVERRIDE_EN, .PULLUP_OVERRIDE_VAL, .DRIVE_DIR_OVERRIDE_EN, .DRIVE_DIR_OVERRIDE_VAL,
    .OUT_VALUE_OVERRIDE_EN, .OUT_VALUE_OVERRIDE_VAL, .LATCH_TOGGLE_OVERRIDE_EN,
    .INPUT_EN_OVERRIDE_EN, .INPUT_EN_OVERRIDE_VAL, .PAD_IN, .PAD_OUT, .PAD_OE_N, .PULLUP_EN,
    .INPUT_EN, .RAW_ALT_INPUT, .ANALOG_PAD_LINK, .PIN_CHANGE_SOURCE_7, .BIT7_IS_CLOCK_PIN);
  pad_far_side u_pad (.clk(CLK), .pad_out(PAD_OUT), .pad_oe_n(PAD_OE_N), .pullup_en(PULLUP_EN),
    .ext_en(ext_en), .ext_level(ext_level), .raw_alt_input(RAW_ALT_INPUT),
    .pad_level(PAD_IN), .alt_sync(alt_sync));
  // 50 ns clock
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR    <= 1'b0;
  endtask
  task automatic rchk(input string name, input logic [1:0] a, input logic [7:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD   <= 1'b0;
    @(negedge CLK);
    rd_val = RDATA;
    chk(name, exp, rd_val);
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic settle;
    repeat (2) @(negedge CLK);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end
  // main sequence
  initial begin
    {RESET_N, WR, RD, SLEEP_CLAMP, ADDR, WDATA} = '0;
    {PULLUP_OVERRIDE_EN, PULLUP_OVERRIDE_VAL, DRIVE_DIR_OVERRIDE_EN, DRIVE_DIR_OVERRIDE_VAL} = '0;
    {OUT_VALUE_OVERRIDE_EN, OUT_VALUE_OVERRIDE_VAL, LATCH_TOGGLE_OVERRIDE_EN} = '0;
    {INPUT_EN_OVERRIDE_EN, INPUT_EN_OVERRIDE_VAL, ext_en, ext_level} = '0;
    {miscompares, samples_checked, cycles} = '0;
    repeat (5) @(posedge CLK);
    RESET_N <= 1'b1;
    @(negedge CLK);
    chk("oe_n at reset", 8'hff, PAD_OE_N);
    chk("pull-up at reset", 8'h00, PULLUP_EN);
    rchk("direction at reset", `ADDR_DIRECTION, 8'h00);
    rchk("latch at reset", `ADDR_LATCH, 8'h00);
    // every direction, latch, pull-up disable combination on pin 0
    for (int k = 0; k < 8; k++) begin
      wr(`ADDR_DIRECTION, {7'h00, k[2]});
      wr(`ADDR_LATCH, {7'h00, k[1]});
      wr(`ADDR_CONTROL, {7'h00, k[0]});
      settle();
      chk("pull-up pin0", {7'h00, k[2:0] == 3'b010}, PULLUP_EN & 8'h01);
      chk("oe_n pin0", {7'h7f, ~k[2]}, PAD_OE_N);
      chk("out pin0", {7'h00, k[2] & k[1]}, PAD_OUT);
    end
    // overrides from peripherals beat the registers
    wr(`ADDR_DIRECTION, 8'h00);
    wr(`ADDR_LATCH, 8'hff);
    @(posedge CLK);
    PULLUP_OVERRIDE_EN     <= 8'hf0;
    PULLUP_OVERRIDE_VAL    <= 8'h3c;
    DRIVE_DIR_OVERRIDE_EN  <= 8'h0f;
    DRIVE_DIR_OVERRIDE_VAL <= 8'h05;
    OUT_VALUE_OVERRIDE_EN  <= 8'h03;
    OUT_VALUE_OVERRIDE_VAL <= 8'h02;
    settle();
    chk("pull-up override", 8'h30, PULLUP_EN);
    chk("oe_n override", 8'hfa, PAD_OE_N);
    chk("out override", 8'h04, PAD_OUT);
    wr(`ADDR_CONTROL, 8'h00);
    settle();
    chk("pull-up mixed", 8'h3f, PULLUP_EN);
    @(posedge CLK);
    {PULLUP_OVERRIDE_EN, DRIVE_DIR_OVERRIDE_EN, OUT_VALUE_OVERRIDE_EN} <= '0;
    // toggling by peripheral and by input register writes
    wr(`ADDR_LATCH, 8'h0f);
    @(posedge CLK);
    LATCH_TOGGLE_OVERRIDE_EN <= 8'h81;
    @(posedge CLK);
    LATCH_TOGGLE_OVERRIDE_EN <= 8'h00;
    rchk("latch toggled", `ADDR_LATCH, 8'h8e);
    wr(`ADDR_INPUT, 8'h3c);
    rchk("latch flipped", `ADDR_LATCH, 8'hb2);
    // input path awake, then clamped with partial override
    wr(`ADDR_LATCH, 8'h00);
    ext_en    <= 8'hff;
    ext_level <= 8'ha5;
    repeat (8) @(negedge CLK);
    rchk("input read", `ADDR_INPUT, 8'ha5);
    chk("pin change 7", 8'h01, {7'h00, PIN_CHANGE_SOURCE_7});
    chk("raw awake", 8'ha5, RAW_ALT_INPUT);
    @(posedge CLK);
    SLEEP_CLAMP           <= 1'b1;
    INPUT_EN_OVERRIDE_EN  <= 8'h0f;
    INPUT_EN_OVERRIDE_VAL <= 8'h03;
    settle();
    chk("input enable", 8'h03, INPUT_EN);
    chk("raw clamped", 8'h01, RAW_ALT_INPUT);
    repeat (6) @(negedge CLK);
    chk("alt sync", 8'h01, alt_sync);
    rchk("input clamped", `ADDR_INPUT, 8'h01);
    @(posedge CLK);
    SLEEP_CLAMP          <= 1'b0;
    INPUT_EN_OVERRIDE_EN <= 8'h00;
    // driven pins loop back through the pad
    ext_en <= 8'h00;
    wr(`ADDR_DIRECTION, 8'hff);
    wr(`ADDR_LATCH, 8'h5a);
    repeat (8) @(negedge CLK);
    rchk("loopback", `ADDR_INPUT, 8'h5a);
    wr(`ADDR_LATCH, 8'hff);
    // oscillator selections for bit 7
    for (int k = 0; k < 4; k++) begin
      wr(`ADDR_CONTROL, ctl_tab[k]);
      settle();
      chk("clock pin", {7'h00, clk_tab[k]}, {7'h00, BIT7_IS_CLOCK_PIN});
      chk("oe_n bit7", {clk_tab[k], 7'h00}, PAD_OE_N);
      rchk("direction bit7", `ADDR_DIRECTION, {~clk_tab[k], 7'h7f});
      rchk("latch bit7", `ADDR_LATCH, {~clk_tab[k], 7'h7f});
      rchk("input bit7", `ADDR_INPUT, {~clk_tab[k], 7'h7f});
    end
    wr(`ADDR_CONTROL, 8'hff);
    rchk("control", `ADDR_CONTROL, 8'h0f);
    @(negedge CLK);
    chk("rdata idle", 8'h00, RDATA);
    stop_test();
  end
endmodule // tb
`default_nettype wire
